//--- rtl/pcb_params.svh
// Constants of the peripheral control block: offsets, field positions, keys, reset values.
// Assumes a single system clock; offsets are byte addresses on the register port.
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH

`define PCB_NUM_LEVELS 32
`define PCB_NUM_PINS 8
`define PCB_FN_W 3
`define PCB_ADDR_W 8

`define PCB_OFS_PENDING 8'h00
`define PCB_OFS_ENABLE 8'h04
`define PCB_OFS_RESULT 8'h08
`define PCB_OFS_LEVELS 8'h0C
`define PCB_OFS_WDT_SVC 8'h10
`define PCB_OFS_WDT_PERIOD 8'h14
`define PCB_OFS_PIN_FN 8'h18
`define PCB_OFS_PIN_DATA 8'h1C
`define PCB_OFS_PIN_EDGE 8'h20
`define PCB_OFS_PIN_COMB 8'h24
`define PCB_OFS_PIN_EDGE_SEL 8'h28

`define PCB_LVL_FIELD_W 5
`define PCB_LVL_PIT_LSB 0
`define PCB_LVL_EDGE_LSB 8
`define PCB_LVL_LEVEL_LSB 16
`define PCB_CMB_EDGE_LSB 8

`define PCB_KEY_FIRST 16'h556C
`define PCB_KEY_SECOND 16'hAA39
`define PCB_WDT_SEL_W 5
`define PCB_WDT_EXP_W 6
`define PCB_WDT_MIN_EXP 6'h02
`define PCB_WDT_MAX_EXP 26
`define PCB_WDT_SEL_RST 5'h18

`define PCB_RST_ENABLE 32'h0000_0000
`define PCB_RST_LEVELS 21'h00_0000
`define PCB_RST_PIN_FN 24'h00_0000
`define PCB_RST_PIN_BYTE 8'h00
`define PCB_PIN_IDLE 1'b1

`endif

//--- rtl/pcb_pkg.sv
// Types shared by the peripheral control block.
// Assumes pcb_params.svh is on the include path.
`include "pcb_params.svh"
`default_nettype none

package pcb_pkg;
    typedef enum logic [2:0] {
        PCB_FN_IN = 3'h0,
        PCB_FN_OUT = 3'h1,
        PCB_FN_EDGE_CPU = 3'h2,
        PCB_FN_LVL_CPU = 3'h3,
        PCB_FN_EDGE_CTL = 3'h4,
        PCB_FN_LVL_CTL = 3'h5
    } pcb_pin_fn_e;

    typedef enum logic {
        PCB_WDT_IDLE = 1'b0,
        PCB_WDT_ARMED = 1'b1
    } pcb_wdt_st_e;

    typedef struct packed {
        logic sel;
        logic we;
        logic [`PCB_ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } pcb_reg_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } pcb_reg_rsp_s;
endpackage

`default_nettype wire

//--- rtl/pcb_pin_sync.sv
// Pin synchroniser with stability filter and edge pulses, one lane per pin.
// Assumes pins are asynchronous to clk_i and idle high.
`include "pcb_params.svh"
`default_nettype none

module pcb_pin_sync (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [`PCB_NUM_PINS-1:0] pin_i,
    output logic [`PCB_NUM_PINS-1:0] stable_o,
    output logic [`PCB_NUM_PINS-1:0] rise_o,
    output logic [`PCB_NUM_PINS-1:0] fall_o
);
    logic [`PCB_NUM_PINS-1:0] s1_reg;
    logic [`PCB_NUM_PINS-1:0] s2_reg;
    logic [`PCB_NUM_PINS-1:0] s3_reg;
    logic [`PCB_NUM_PINS-1:0] stable_reg;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s1_reg <= {`PCB_NUM_PINS{`PCB_PIN_IDLE}};
            s2_reg <= {`PCB_NUM_PINS{`PCB_PIN_IDLE}};
            s3_reg <= {`PCB_NUM_PINS{`PCB_PIN_IDLE}};
        end
        else
        begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change is accepted only once the second and third stages agree.
    for (genvar i = 0; i < `PCB_NUM_PINS; i++)
    begin : g_lane
        logic take;
        assign take = (s2_reg[i] == s3_reg[i]) && (s3_reg[i] != stable_reg[i]);
        assign rise_o[i] = take && s3_reg[i];
        assign fall_o[i] = take && !s3_reg[i];
        always_ff @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
                stable_reg[i] <= `PCB_PIN_IDLE;
            else if (take)
                stable_reg[i] <= s3_reg[i];
        end
    end

    assign stable_o = stable_reg;
endmodule

`default_nettype wire

//--- rtl/pcb_watchdog.sv
// Software watchdog: two-key service sequence and timeout counter.
// Assumes limit_i is stable most of the time and written by the register file.
`include "pcb_params.svh"
`default_nettype none

module pcb_watchdog #(
    parameter int CNT_W = `PCB_WDT_MAX_EXP
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic svc_wr_i,
    input wire logic [15:0] svc_data_i,
    input wire logic [CNT_W-1:0] limit_i,
    output logic [CNT_W-1:0] count_o,
    output logic armed_o,
    output logic clear_o,
    output logic reset_o
);
    pcb_pkg::pcb_wdt_st_e state_reg;
    logic [CNT_W-1:0] count_reg;
    logic reset_reg;
    logic timeout;

    // Any foreign value, or the second key out of order, drops back to idle.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_reg <= pcb_pkg::PCB_WDT_IDLE;
        else if (svc_wr_i)
        begin
            if (svc_data_i == `PCB_KEY_FIRST)
                state_reg <= pcb_pkg::PCB_WDT_ARMED;
            else
                state_reg <= pcb_pkg::PCB_WDT_IDLE;
        end
    end

    assign clear_o = svc_wr_i && (svc_data_i == `PCB_KEY_SECOND)
        && (state_reg == pcb_pkg::PCB_WDT_ARMED);
    // Greater-or-equal keeps a shortened period from being skipped past.
    assign timeout = (count_reg >= limit_i);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            count_reg <= '0;
        else if (clear_o || timeout)
            count_reg <= '0;
        else
            count_reg <= count_reg + 1'b1;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reset_reg <= 1'b0;
        else
            reset_reg <= timeout && !clear_o;
    end

    assign count_o = count_reg;
    assign armed_o = (state_reg == pcb_pkg::PCB_WDT_ARMED);
    assign reset_o = reset_reg;
endmodule

`default_nettype wire

//--- rtl/pcb_top.sv
// Peripheral control block: interrupt consolidator, software watchdog, pin port.
// Assumes one system clock and a simple register port driven by the load/store bus.
//
// Functional notes
// - Enabled sources merge into one core request.
// - Thirty-two levels, each masked on its own.
// - Request pins work on edge or level.
// - Read-only pending bits follow each level's signal.
// - One writable enable bit per level.
// - Result is pending AND enable; drives request.
// - Three 5-bit fields place timer and pins.
// - No hardware priority among levels.
// - Completed sequence restarts the watchdog count.
// - Timeout before service issues a system reset.
// - Any other value cancels a partial sequence.
// - Timeout period selectable, counted in clock cycles.
// - Request pins double as plain digital I/O.
// - Per-pin function picks one of six uses.
// - Data register reads inputs, drives outputs.
// - Edge status bit sets on selected transition.
// - Data and edge status share one register.
`include "pcb_params.svh"
`default_nettype none

module pcb_top #(
    parameter int WDT_MAX_EXP = `PCB_WDT_MAX_EXP
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire pcb_pkg::pcb_reg_req_s reg_req_i,
    output pcb_pkg::pcb_reg_rsp_s reg_rsp_o,
    input wire logic [`PCB_NUM_LEVELS-1:0] irq_src_i,
    input wire logic pit_req_i,
    input wire logic [`PCB_NUM_PINS-1:0] pin_i,
    output logic [`PCB_NUM_PINS-1:0] pin_o,
    output logic [`PCB_NUM_PINS-1:0] pin_oe_o,
    output logic [`PCB_NUM_PINS-1:0] pin_core_irq_o,
    output logic core_irq_o,
    output logic wdt_reset_o
);
    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    logic wr;
    logic rd;
    logic [31:0] wd;
    assign wr = reg_req_i.sel && reg_req_i.we;
    assign rd = reg_req_i.sel && !reg_req_i.we;
    assign wd = reg_req_i.wdata;

    function automatic logic hit(input logic [`PCB_ADDR_W-1:0] a,
                                 input logic [`PCB_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_enable;
    logic wr_levels;
    logic wr_svc;
    logic wr_period;
    logic wr_fn;
    logic wr_data;
    logic wr_edge;
    logic wr_comb;
    logic wr_esel;
    assign wr_enable = wr && hit(reg_req_i.addr, `PCB_OFS_ENABLE);
    assign wr_levels = wr && hit(reg_req_i.addr, `PCB_OFS_LEVELS);
    assign wr_svc = wr && hit(reg_req_i.addr, `PCB_OFS_WDT_SVC);
    assign wr_period = wr && hit(reg_req_i.addr, `PCB_OFS_WDT_PERIOD);
    assign wr_fn = wr && hit(reg_req_i.addr, `PCB_OFS_PIN_FN);
    assign wr_data = wr && hit(reg_req_i.addr, `PCB_OFS_PIN_DATA);
    assign wr_edge = wr && hit(reg_req_i.addr, `PCB_OFS_PIN_EDGE);
    assign wr_comb = wr && hit(reg_req_i.addr, `PCB_OFS_PIN_COMB);
    assign wr_esel = wr && hit(reg_req_i.addr, `PCB_OFS_PIN_EDGE_SEL);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [`PCB_NUM_LEVELS-1:0] enable_reg;
    logic [20:0] levels_reg;
    logic [`PCB_WDT_SEL_W-1:0] period_reg;
    logic [`PCB_NUM_PINS*`PCB_FN_W-1:0] fn_reg;
    logic [`PCB_NUM_PINS-1:0] pin_out_reg;
    logic [`PCB_NUM_PINS-1:0] esel_reg;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            enable_reg <= `PCB_RST_ENABLE;
        else if (wr_enable)
            enable_reg <= wd;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            levels_reg <= `PCB_RST_LEVELS;
        else if (wr_levels)
            levels_reg <= wd[20:0];
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            period_reg <= `PCB_WDT_SEL_RST;
        else if (wr_period)
            period_reg <= wd[`PCB_WDT_SEL_W-1:0];
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            fn_reg <= `PCB_RST_PIN_FN;
        else if (wr_fn)
            fn_reg <= wd[`PCB_NUM_PINS*`PCB_FN_W-1:0];
    end

    // Output latch is written through either the data or the combined view.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pin_out_reg <= `PCB_RST_PIN_BYTE;
        else if (wr_data || wr_comb)
            pin_out_reg <= wd[`PCB_NUM_PINS-1:0];
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            esel_reg <= `PCB_RST_PIN_BYTE;
        else if (wr_esel)
            esel_reg <= wd[`PCB_NUM_PINS-1:0];
    end

    // ------------------------------------------------------------
    // Pin port
    // ------------------------------------------------------------
    logic [`PCB_NUM_PINS-1:0] pin_stable;
    logic [`PCB_NUM_PINS-1:0] pin_rise;
    logic [`PCB_NUM_PINS-1:0] pin_fall;

    pcb_pin_sync u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(pin_i),
        .stable_o(pin_stable),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    logic [`PCB_NUM_PINS-1:0] edge_reg;
    logic [`PCB_NUM_PINS-1:0] edge_hit;
    logic [`PCB_NUM_PINS-1:0] edge_w1c;
    logic [`PCB_NUM_PINS-1:0] oe_w;
    logic [`PCB_NUM_PINS-1:0] ctl_edge;
    logic [`PCB_NUM_PINS-1:0] ctl_lvl;
    logic [`PCB_NUM_PINS-1:0] cpu_req;
    logic [`PCB_NUM_PINS-1:0] pin_rd;

    // Level request pins are active low; a function code of 6 or 7 acts as input.
    for (genvar i = 0; i < `PCB_NUM_PINS; i++)
    begin : g_pin
        pcb_pkg::pcb_pin_fn_e fn;
        assign fn = pcb_pkg::pcb_pin_fn_e'(fn_reg[`PCB_FN_W*i +: `PCB_FN_W]);
        assign edge_hit[i] = esel_reg[i] ? pin_rise[i] : pin_fall[i];
        assign oe_w[i] = (fn == pcb_pkg::PCB_FN_OUT);
        assign ctl_edge[i] = (fn == pcb_pkg::PCB_FN_EDGE_CTL) && edge_reg[i];
        assign ctl_lvl[i] = (fn == pcb_pkg::PCB_FN_LVL_CTL) && !pin_stable[i];
        assign cpu_req[i] = ((fn == pcb_pkg::PCB_FN_EDGE_CPU) && edge_reg[i])
            || ((fn == pcb_pkg::PCB_FN_LVL_CPU) && !pin_stable[i]);
        assign pin_rd[i] = oe_w[i] ? pin_out_reg[i] : pin_stable[i];
    end

    assign edge_w1c = wr_edge ? wd[`PCB_NUM_PINS-1:0]
        : (wr_comb ? wd[`PCB_CMB_EDGE_LSB +: `PCB_NUM_PINS] : '0);

    // A transition in the clearing cycle still leaves the bit set.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            edge_reg <= '0;
        else
            edge_reg <= (edge_reg & ~edge_w1c) | edge_hit;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_oe_o <= '0;
            pin_core_irq_o <= '0;
        end
        else
        begin
            pin_oe_o <= oe_w;
            pin_core_irq_o <= cpu_req;
        end
    end

    assign pin_o = pin_out_reg;

    // ------------------------------------------------------------
    // Interrupt consolidator
    // ------------------------------------------------------------
    logic [`PCB_LVL_FIELD_W-1:0] lvl_pit;
    logic [`PCB_LVL_FIELD_W-1:0] lvl_edge;
    logic [`PCB_LVL_FIELD_W-1:0] lvl_level;
    logic [`PCB_NUM_LEVELS-1:0] pend_next;
    logic [`PCB_NUM_LEVELS-1:0] pend_reg;
    logic [`PCB_NUM_LEVELS-1:0] result;
    assign lvl_pit = levels_reg[`PCB_LVL_PIT_LSB +: `PCB_LVL_FIELD_W];
    assign lvl_edge = levels_reg[`PCB_LVL_EDGE_LSB +: `PCB_LVL_FIELD_W];
    assign lvl_level = levels_reg[`PCB_LVL_LEVEL_LSB +: `PCB_LVL_FIELD_W];

    always_comb
    begin
        pend_next = irq_src_i;
        if (pit_req_i)
            pend_next[lvl_pit] = 1'b1;
        if (|ctl_edge)
            pend_next[lvl_edge] = 1'b1;
        if (|ctl_lvl)
            pend_next[lvl_level] = 1'b1;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pend_reg <= '0;
        else
            pend_reg <= pend_next;
    end

    // Every level weighs the same; the handler reads the result and picks.
    assign result = pend_reg & enable_reg;
    assign core_irq_o = |result;

    // ------------------------------------------------------------
    // Software watchdog
    // ------------------------------------------------------------
    logic [`PCB_WDT_EXP_W-1:0] wdt_exp;
    logic [WDT_MAX_EXP-1:0] wdt_limit;
    logic [WDT_MAX_EXP-1:0] wdt_count;
    logic wdt_armed;
    logic wdt_clear;

    // Period is two to the power of (minimum + select), capped at the top.
    always_comb
    begin
        wdt_exp = `PCB_WDT_MIN_EXP + {1'b0, period_reg};
        if (wdt_exp > `PCB_WDT_EXP_W'(WDT_MAX_EXP))
            wdt_exp = `PCB_WDT_EXP_W'(WDT_MAX_EXP);
        wdt_limit = {WDT_MAX_EXP{1'b1}} >> (`PCB_WDT_EXP_W'(WDT_MAX_EXP) - wdt_exp);
    end

    pcb_watchdog #(
        .CNT_W(WDT_MAX_EXP)
    ) u_wdt (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .svc_wr_i(wr_svc),
        .svc_data_i(wd[15:0]),
        .limit_i(wdt_limit),
        .count_o(wdt_count),
        .armed_o(wdt_armed),
        .clear_o(wdt_clear),
        .reset_o(wdt_reset_o)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    logic ack_reg;
    logic [31:0] rdata_reg;

    always_comb
    begin
        rd_mux = '0;
        if (hit(reg_req_i.addr, `PCB_OFS_PENDING))
            rd_mux = pend_reg;
        else if (hit(reg_req_i.addr, `PCB_OFS_ENABLE))
            rd_mux = enable_reg;
        else if (hit(reg_req_i.addr, `PCB_OFS_RESULT))
            rd_mux = result;
        else if (hit(reg_req_i.addr, `PCB_OFS_LEVELS))
            rd_mux = {11'h000, levels_reg};
        else if (hit(reg_req_i.addr, `PCB_OFS_WDT_SVC))
            rd_mux = {31'h0, wdt_armed};
        else if (hit(reg_req_i.addr, `PCB_OFS_WDT_PERIOD))
            rd_mux = {27'h0, period_reg};
        else if (hit(reg_req_i.addr, `PCB_OFS_PIN_FN))
            rd_mux = {8'h00, fn_reg};
        else if (hit(reg_req_i.addr, `PCB_OFS_PIN_DATA))
            rd_mux = {24'h00_0000, pin_rd};
        else if (hit(reg_req_i.addr, `PCB_OFS_PIN_EDGE))
            rd_mux = {24'h00_0000, edge_reg};
        else if (hit(reg_req_i.addr, `PCB_OFS_PIN_COMB))
            rd_mux = {16'h0000, edge_reg, pin_rd};
        else if (hit(reg_req_i.addr, `PCB_OFS_PIN_EDGE_SEL))
            rd_mux = {24'h00_0000, esel_reg};
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else
        begin
            ack_reg <= reg_req_i.sel;
            rdata_reg <= rd ? rd_mux : '0;
        end
    end

    assign reg_rsp_o.ack = ack_reg;
    assign reg_rsp_o.rdata = rdata_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_MASK_ALL: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (enable_reg == '0) |-> !core_irq_o)
        else $error("request raised with every level masked");

    AST_PEND_FOLLOWS: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        1'b1 |=> ((pend_reg & $past(irq_src_i)) == $past(irq_src_i)))
        else $error("pending bit missed an active source");

    AST_ENABLE_WRITE: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wr_enable |=> (enable_reg == $past(wd)))
        else $error("enable register did not take the written value");

    AST_SRC_TO_REQ: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (irq_src_i[0] && enable_reg[0] && !wr_enable) |=> core_irq_o)
        else $error("enabled source did not raise the core request");

    AST_RESULT_READ: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (rd && hit(reg_req_i.addr, `PCB_OFS_RESULT))
            |=> (reg_rsp_o.ack && reg_rsp_o.rdata == $past(pend_reg & enable_reg)))
        else $error("result read does not match pending and enable");

    AST_PIT_LEVEL: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        pit_req_i |=> pend_reg[$past(lvl_pit)])
        else $error("timer request missed its assigned level");

    AST_WDT_CLEAR: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_svc && wd[15:0] == `PCB_KEY_SECOND && wdt_armed)
            |=> (wdt_count == '0) ##1 (wdt_count == 1) ##0 !wdt_reset_o)
        else $error("second key did not restart the watchdog");

    AST_WDT_CANCEL: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_svc && wd[15:0] != `PCB_KEY_FIRST) |=> !wdt_armed)
        else $error("foreign value left the sequence armed");

    AST_WDT_TIMEOUT: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wdt_count >= wdt_limit && !wdt_clear) |=> (wdt_reset_o && wdt_count == '0))
        else $error("watchdog expired without issuing reset");

    AST_WDT_SERVED: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wdt_clear |=> !wdt_reset_o)
        else $error("reset issued in the servicing cycle");

    AST_EDGE_SET: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        edge_hit[1] |=> edge_reg[1] [*2] or (edge_reg[1] ##1 $past(edge_w1c[1])))
        else $error("selected transition did not set edge status");

    AST_EDGE_STICKY: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (edge_reg[1] && !edge_w1c[1]) |=> edge_reg[1])
        else $error("edge status dropped without a clearing one");

    AST_PIN_DRIVE: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (wr_data && g_pin[0].fn == pcb_pkg::PCB_FN_OUT && !wr_fn)
            |=> (pin_oe_o[0] && pin_o[0] == $past(wd[0])))
        else $error("output pin not driven with written data");
endmodule

`default_nettype wire

//--- test/pcb_core_model.sv
// Core side of the request line: counts request cycles and watchdog resets.
// Assumes the same clock and reset as the block.
`default_nettype none

module pcb_core_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic irq_i,
    input wire logic wdt_reset_i,
    output int irq_cycles_o,
    output int resets_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // The core only samples the level; it never acknowledges, like a plain input.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            irq_cycles_o <= 0;
            resets_o <= 0;
        end
        else
        begin
            irq_cycles_o <= irq_cycles_o + int'(irq_i);
            resets_o <= resets_o + int'(wdt_reset_i);
        end
    end
endmodule

`default_nettype wire

//--- test/pcb_top_tb.sv
// Self-checking bench of the peripheral control block.
// Assumes the register port answers one cycle after each access.
`default_nettype none

module pcb_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, resetn_i, pit_req_i;
    pcb_pkg::pcb_reg_req_s req;
    pcb_pkg::pcb_reg_rsp_s rsp;
    logic [31:0] irq_src_i, rd, src, en, exp_pend;
    logic [7:0] pin_i, pin_o, pin_oe_o, pin_core_irq_o;
    logic core_irq_o, wdt_reset_o;
    int mismatches = 0, compares = 0, irq_cycles, resets, r0;
    int seed = 32'h8b09129a;

    pcb_top #(.WDT_MAX_EXP(6)) i_pcb_top (.clk_i(clk_i), .resetn_i(resetn_i),
        .reg_req_i(req), .reg_rsp_o(rsp), .irq_src_i(irq_src_i), .pit_req_i(pit_req_i),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_core_irq_o(pin_core_irq_o),
        .core_irq_o(core_irq_o), .wdt_reset_o(wdt_reset_o));
    pcb_core_model i_pcb_core_model (.clk_i(clk_i), .resetn_i(resetn_i), .irq_i(core_irq_o),
        .wdt_reset_i(wdt_reset_o), .irq_cycles_o(irq_cycles), .resets_o(resets));

    initial
    begin
        clk_i = 0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access; the extra cycle keeps sel from being driven twice in one step.
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] wd);
        req = '{sel: 1'b1, we: we, addr: a, wdata: wd};
        @(posedge clk_i);
        #1;
        check("ack", 32'h1, {31'h0, rsp.ack});
        rd = rsp.rdata;
        req.sel = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        acc(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #50000;
        mismatches++;
        final_report();
    end

    initial
    begin
        req = '0;
        irq_src_i = 32'h0;
        pit_req_i = 1'b0;
        pin_i = 8'hFF;
        resetn_i = 1'b0;
        wait_n(8);
        resetn_i = 1'b1;
        wait_n(1);
        rdc(8'h04, 32'h0, "enable_rst");
        rdc(8'h30, 32'h0, "unmapped");
        acc(1'b1, 8'h18, 32'h14AC1);
        rdc(8'h18, 32'h14AC1, "pin_fn");
        acc(1'b1, 8'h0C, 32'h07_06_05);
        rdc(8'h0C, 32'h07_06_05, "levels");
        $display("test registers done");
        repeat (6)
        begin
            src = $random(seed) & 32'hFFFF_FF1F;
            en = $random(seed);
            pit_req_i = src[0];
            irq_src_i = src;
            acc(1'b1, 8'h04, en);
            exp_pend = src | {26'h0, src[0], 5'h0};
            rdc(8'h00, exp_pend, "pending");
            rdc(8'h08, exp_pend & en, "result");
            check("core_irq", {31'h0, |(exp_pend & en)}, {31'h0, core_irq_o});
        end
        check("core_seen", 32'h1, {31'h0, irq_cycles > 0});
        $display("test interrupts done");
        acc(1'b1, 8'h1C, 32'h1);
        check("pin_o", 32'h1, {24'h0, pin_o & 8'h01});
        check("pin_oe", 32'h1, {24'h0, pin_oe_o});
        pin_i[1] = 1'b0;
        wait_n(8);
        rdc(8'h20, 32'h02, "edge_set");
        acc(1'b1, 8'h20, 32'h0);
        rdc(8'h24, 32'h02FD, "combined");
        acc(1'b1, 8'h24, 32'h0200);
        rdc(8'h20, 32'h0, "edge_clr");
        acc(1'b1, 8'h28, 32'h02);
        pin_i[5:1] = 5'b00001;
        wait_n(8);
        check("pin_core_irq", 32'h24, {24'h0, pin_core_irq_o});
        rdc(8'h00, exp_pend | 32'hC0, "level_group");
        rdc(8'h20, 32'h3E, "edge_sel");
        $display("test pins done");
        acc(1'b1, 8'h14, 32'h0);
        r0 = resets;
        wait_n(40);
        check("short_period", 32'h1, {31'h0, resets - r0 >= 5});
        acc(1'b1, 8'h14, 32'h4);
        r0 = resets;
        repeat (3)
        begin
            wait_n(40);
            acc(1'b1, 8'h10, 32'h556C);
            rdc(8'h10, 32'h1, "armed");
            acc(1'b1, 8'h10, 32'hAA39);
        end
        check("serviced", r0, resets);
        acc(1'b1, 8'h10, 32'h556C);
        acc(1'b1, 8'h10, 32'h1234);
        rdc(8'h10, 32'h0, "disarmed");
        acc(1'b1, 8'h10, 32'hAA39);
        wait_n(60);
        check("timeout", 32'h1, {31'h0, resets > r0});
        $display("test watchdog done");
        final_report();
    end
endmodule

`default_nettype wire
